//--- rtl/acsf_pkg.sv
// Package with register offsets, field positions, the mode register reset value and the unmapped read data of the conversion status flag block.
package acsf_pkg;
	localparam int NUM_CH = 4;
	localparam int RES_W = 10;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_MODE = 8'h04;
	localparam logic [7:0] OFF_CH_EN = 8'h10;
	localparam logic [7:0] OFF_CH_DIS = 8'h14;
	localparam logic [7:0] OFF_CH_STAT = 8'h18;
	localparam logic [7:0] OFF_STATUS = 8'h1c;
	localparam logic [7:0] OFF_LAST = 8'h20;
	localparam logic [7:0] OFF_CH_BASE = 8'h30;
	localparam int CTRL_START_BIT = 1;
	localparam int MODE_SLEEP_BIT = 5;
	localparam int STAT_EOC_LSB = 0;
	localparam int STAT_OVR_LSB = 8;
	localparam int STAT_READY_BIT = 16;
	localparam int STAT_GOVR_BIT = 17;
	localparam int STAT_SLEEP_BIT = 18;
	localparam int STAT_BUSY_BIT = 19;
	localparam logic [31:0] MODE_RESET = 32'h0000_0000;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

//--- rtl/acsf_flag_core.sv
// Flag update logic for end-of-conversion, overrun, ready and general overrun.
`timescale 1ns/1ps
module acsf_flag_core #(
	parameter int NUM_CH = 4
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic conv_done,
	input wire logic [1:0] conv_ch,
	input wire logic [NUM_CH-1:0] ch_enabled,
	input wire logic rd_status,
	input wire logic rd_last,
	input wire logic rd_ch,
	input wire logic [1:0] rd_ch_idx,
	output logic store,
	output logic [NUM_CH-1:0] eoc_flags,
	output logic [NUM_CH-1:0] channel_overrun_flag,
	output logic result_ready_flag,
	output logic global_overrun_flag
);
	logic [NUM_CH-1:0] next_eoc;
	logic [NUM_CH-1:0] next_ovr;
	logic next_ready;
	logic next_govr;

	always_comb begin
		store = conv_done && ch_enabled[conv_ch];
		next_ready = result_ready_flag;
		next_govr = global_overrun_flag;
		if (rd_last) begin
			next_ready = 1'b0;
		end
		if (store) begin
			next_ready = 1'b1;
		end
		if (rd_status) begin
			next_govr = 1'b0;
		end
		if (store && result_ready_flag && !rd_last) begin
			next_govr = 1'b1;
		end
	end

	for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
		always_comb begin
			next_eoc[i] = eoc_flags[i];
			next_ovr[i] = channel_overrun_flag[i];
			if (rd_last || (rd_ch && rd_ch_idx == 2'(i))) begin
				next_eoc[i] = 1'b0;
			end
			if (rd_status) begin
				next_ovr[i] = 1'b0;
			end
			if (store && conv_ch == 2'(i)) begin
				next_eoc[i] = 1'b1;
				if (eoc_flags[i]) begin
					next_ovr[i] = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			eoc_flags <= '0;
			channel_overrun_flag <= '0;
			result_ready_flag <= 1'b0;
			global_overrun_flag <= 1'b0;
		end else begin
			eoc_flags <= next_eoc;
			channel_overrun_flag <= next_ovr;
			result_ready_flag <= next_ready;
			global_overrun_flag <= next_govr;
		end
	end
endmodule

//--- rtl/acsf_top.sv
// Converter status flag block with its Avalon-MM register slave.
`timescale 1ns/1ps
module acsf_top #(
	parameter int NUM_CH = acsf_pkg::NUM_CH,
	parameter int RES_W = acsf_pkg::RES_W
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic conv_done,
	input wire logic [1:0] conv_ch,
	input wire logic [RES_W-1:0] conv_data,
	output logic conv_start,
	output logic conv_sleep,
	output logic [NUM_CH-1:0] ch_enable
);
	////////////////////////////////////////////////////////////////////////////////
	logic ack;
	logic next_ack;
	logic [31:0] next_readdata;
	logic [31:0] mode_reg;
	logic [31:0] next_mode;
	logic [NUM_CH-1:0] next_ch_enable;
	logic next_start;
	logic busy;
	logic next_busy;
	logic sleep_state;
	logic next_sleep_state;
	logic [RES_W-1:0] ch_result [NUM_CH];
	logic [RES_W-1:0] last_result_reg;
	logic [1:0] last_ch;
	logic acc;
	logic rd_status;
	logic rd_last;
	logic rd_ch;
	logic [1:0] rd_ch_idx;
	logic store;
	logic [NUM_CH-1:0] eoc_flags;
	logic [NUM_CH-1:0] ovr_flags;
	logic ready_flag;
	logic govr_flag;
	logic [31:0] status_word;

	////////////////////////////////////////////////////////////////////////////////
	// Requests are answered one cycle after they appear; reads act at the answer edge.
	always_comb begin
		acc = (avs_read || avs_write) && !ack;
		rd_status = avs_read && ack && avs_address == acsf_pkg::OFF_STATUS;
		rd_last = avs_read && ack && avs_address == acsf_pkg::OFF_LAST;
		rd_ch = avs_read && ack && avs_address[7:4] == acsf_pkg::OFF_CH_BASE[7:4]
			&& {1'b0, avs_address[3:2]} < 3'(NUM_CH);
		rd_ch_idx = avs_address[3:2];
		avs_waitrequest = !ack && (avs_read || avs_write);
	end

	acsf_flag_core #(
		.NUM_CH(NUM_CH)
	) u_core (
		.mclk(mclk),
		.reset(reset),
		.conv_done(conv_done),
		.conv_ch(conv_ch),
		.ch_enabled(ch_enable),
		.rd_status(rd_status),
		.rd_last(rd_last),
		.rd_ch(rd_ch),
		.rd_ch_idx(rd_ch_idx),
		.store(store),
		.eoc_flags(eoc_flags),
		.channel_overrun_flag(ovr_flags),
		.result_ready_flag(ready_flag),
		.global_overrun_flag(govr_flag)
	);

	always_comb begin
		status_word = '0;
		status_word[acsf_pkg::STAT_EOC_LSB +: NUM_CH] = eoc_flags;
		status_word[acsf_pkg::STAT_OVR_LSB +: NUM_CH] = ovr_flags;
		status_word[acsf_pkg::STAT_READY_BIT] = ready_flag;
		status_word[acsf_pkg::STAT_GOVR_BIT] = govr_flag;
		status_word[acsf_pkg::STAT_SLEEP_BIT] = sleep_state;
		status_word[acsf_pkg::STAT_BUSY_BIT] = busy;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus slave, control and mode registers.
	always_comb begin
		next_ack = acc;
		next_readdata = avs_readdata;
		next_mode = mode_reg;
		next_ch_enable = ch_enable;
		next_start = 1'b0;
		if (acc && avs_read) begin
			next_readdata = acsf_pkg::UNMAPPED_DATA;
			case (avs_address)
				acsf_pkg::OFF_MODE: next_readdata = mode_reg;
				acsf_pkg::OFF_CH_STAT: next_readdata = 32'(ch_enable);
				acsf_pkg::OFF_STATUS: next_readdata = status_word;
				acsf_pkg::OFF_LAST: next_readdata = {18'h0, last_ch, 2'h0, last_result_reg};
				default: begin
					if (avs_address[7:4] == acsf_pkg::OFF_CH_BASE[7:4]
						&& {1'b0, avs_address[3:2]} < 3'(NUM_CH)) begin
						next_readdata = 32'(ch_result[avs_address[3:2]]);
					end
				end
			endcase
		end
		if (ack && avs_write) begin
			case (avs_address)
				acsf_pkg::OFF_CTRL: begin
					if (avs_byteenable[0]) begin
						next_start = avs_writedata[acsf_pkg::CTRL_START_BIT];
					end
				end
				acsf_pkg::OFF_MODE: begin
					for (int b = 0; b < 4; b++) begin
						if (avs_byteenable[b]) begin
							next_mode[b*8 +: 8] = avs_writedata[b*8 +: 8];
						end
					end
				end
				acsf_pkg::OFF_CH_EN: begin
					if (avs_byteenable[0]) begin
						next_ch_enable = ch_enable | avs_writedata[NUM_CH-1:0];
					end
				end
				acsf_pkg::OFF_CH_DIS: begin
					if (avs_byteenable[0]) begin
						next_ch_enable = ch_enable & ~avs_writedata[NUM_CH-1:0];
					end
				end
				default: next_start = 1'b0;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			ack <= 1'b0;
			avs_readdata <= '0;
			mode_reg <= acsf_pkg::MODE_RESET;
			ch_enable <= '0;
			conv_start <= 1'b0;
		end else begin
			ack <= next_ack;
			avs_readdata <= next_readdata;
			mode_reg <= next_mode;
			ch_enable <= next_ch_enable;
			conv_start <= next_start;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Result storage and sleep sequencing.
	always_comb begin
		next_busy = busy;
		next_sleep_state = sleep_state;
		if (conv_start) begin
			next_busy = 1'b1;
			next_sleep_state = 1'b0;
		end
		if (conv_done) begin
			next_busy = 1'b0;
			next_sleep_state = mode_reg[acsf_pkg::MODE_SLEEP_BIT];
		end
		if (!mode_reg[acsf_pkg::MODE_SLEEP_BIT]) begin
			next_sleep_state = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			busy <= 1'b0;
			sleep_state <= 1'b0;
			conv_sleep <= 1'b0;
			last_result_reg <= '0;
			last_ch <= 2'h0;
		end else begin
			busy <= next_busy;
			sleep_state <= next_sleep_state;
			conv_sleep <= next_sleep_state;
			if (store) begin
				last_result_reg <= conv_data;
				last_ch <= conv_ch;
			end
		end
	end

	for (genvar i = 0; i < NUM_CH; i++) begin : g_res
		always_ff @(posedge mclk) begin
			if (reset) begin
				ch_result[i] <= '0;
			end else if (store && conv_ch == 2'(i)) begin
				ch_result[i] <= conv_data;
			end
		end
	end
endmodule

//--- test/acsf_chk.sv
// Port checks for the conversion status flag block.
`timescale 1ns/1ps
module acsf_chk #(
	parameter int NUM_CH = 4
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic conv_done,
	input wire logic conv_start,
	input wire logic conv_sleep,
	input wire logic [NUM_CH-1:0] ch_enable
);
	logic seen;
	logic next_seen;
	logic wok;
	logic rok;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	assign wok = avs_write && !avs_waitrequest;
	assign rok = avs_read && !avs_waitrequest;
	always_comb begin
		next_seen = !reset && (seen || conv_done);
	end
	always_ff @(posedge mclk) begin
		seen <= next_seen;
	end
	////////////////////////////////////////////////////////////////////////////////
	AST_RST_CLR: assert property (disable iff (1'b0)
		reset |=> ch_enable == '0 && !conv_sleep && !conv_start) else $error("reset state");
	AST_NO_FLAG: assert property (rok && avs_address == acsf_pkg::OFF_STATUS && !seen
		|-> avs_readdata[17:0] == 18'h0) else $error("flag without conversion");
	AST_SLP_CONV: assert property ($rose(conv_sleep)
		|-> $past(conv_done) || $past(conv_done, 2)) else $error("sleep without conversion");
	AST_START: assert property (wok && avs_address == acsf_pkg::OFF_CTRL
		&& avs_writedata[acsf_pkg::CTRL_START_BIT] |=> conv_start) else $error("no start");
	AST_START_ONE: assert property (conv_start |=> !conv_start) else $error("long start");
	AST_CH_EN: assert property (wok && avs_address == acsf_pkg::OFF_CH_EN |=>
		ch_enable == ($past(ch_enable) | $past(avs_writedata[NUM_CH-1:0]))) else $error("enable");
	AST_CH_DIS: assert property (wok && avs_address == acsf_pkg::OFF_CH_DIS |=>
		ch_enable == ($past(ch_enable) & ~$past(avs_writedata[NUM_CH-1:0]))) else $error("disable");
	AST_CH_HOLD: assert property (!(wok && avs_address[7:4] == 4'h1)
		|=> $stable(ch_enable)) else $error("enable moved");
	////////////////////////////////////////////////////////////////////////////////
	cover property (rok && avs_address == acsf_pkg::OFF_LAST);
	cover property (conv_done && rok);
	cover property ($rose(conv_sleep));
endmodule

//--- test/tb_acsf_top.sv
// Directed bench for the conversion status flag block.
`timescale 1ns/1ps
module tb_acsf_top;
	localparam logic [31:0] RDY = 32'h1 << acsf_pkg::STAT_READY_BIT;
	localparam logic [31:0] GOV = 32'h1 << acsf_pkg::STAT_GOVR_BIT;
	localparam logic [7:0] ST = acsf_pkg::OFF_STATUS;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic conv_done = 1'b0;
	logic [1:0] conv_ch = 2'h0;
	logic [9:0] conv_data = 10'h0;
	logic conv_start;
	logic conv_sleep;
	logic [3:0] ch_enable;
	int err_count = 0;
	int total_checks = 0;
	always #10 mclk = ~mclk;
	acsf_top DUT(.mclk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .conv_done, .conv_ch,
		.conv_data, .conv_start, .conv_sleep, .ch_enable);
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		avs_address <= a;
		avs_writedata <= v;
		avs_write <= 1'b1;
		do @(posedge mclk); while (avs_waitrequest);
		avs_write <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge mclk); while (avs_waitrequest);
		d = avs_readdata;
		avs_read <= 1'b0;
		@(posedge mclk);
		chk(d, e);
	endtask
	task automatic cv(input logic [1:0] c, input logic [9:0] v, input int lag);
		repeat (lag) @(posedge mclk);
		conv_ch <= c;
		conv_data <= v;
		conv_done <= 1'b1;
		@(posedge mclk);
		conv_done <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic results;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		rd(ST, 32'h0);
		rd(acsf_pkg::OFF_CH_STAT, 32'h0);
		rd(8'h08, acsf_pkg::UNMAPPED_DATA);
		wr(acsf_pkg::OFF_CH_EN, 32'hf);
		cv(2'h0, 10'h155, 0);
		rd(ST, RDY | 32'h1);
		rd(acsf_pkg::OFF_CH_BASE, 32'h155);
		rd(ST, RDY);
		rd(acsf_pkg::OFF_LAST, 32'h155);
		rd(ST, 32'h0);
		cv(2'h1, 10'h2aa, 0);
		cv(2'h1, 10'h0f0, 0);
		rd(ST, RDY | GOV | 32'h202);
		rd(ST, RDY | 32'h2);
		fork
			rd(acsf_pkg::OFF_CH_BASE + 8'h04, 32'h0f0);
			cv(2'h2, 10'h3ff, 1);
		join
		rd(ST, RDY | GOV | 32'h4);
		fork
			rd(ST, RDY | 32'h4);
			cv(2'h0, 10'h011, 1);
		join
		rd(ST, RDY | GOV | 32'h5);
		cv(2'h1, 10'h066, 0);
		rd(acsf_pkg::OFF_LAST, 32'h1066);
		fork
			rd(ST, GOV);
			cv(2'h3, 10'h077, 1);
		join
		rd(ST, RDY | 32'h8);
		fork
			wr(acsf_pkg::OFF_CH_DIS, 32'h8);
			cv(2'h1, 10'h123, 1);
		join
		rd(ST, RDY | GOV | 32'ha);
		rd(acsf_pkg::OFF_LAST, 32'h1123);
		cv(2'h3, 10'h200, 0);
		rd(ST, 32'h0);
		wr(acsf_pkg::OFF_MODE, 32'h20);
		repeat (4) @(posedge mclk);
		chk(32'(conv_sleep), 32'h0);
		wr(acsf_pkg::OFF_CTRL, 32'h2);
		cv(2'h0, 10'h001, 0);
		@(posedge mclk);
		chk(32'(conv_sleep), 32'h1);
		results();
	end
	initial begin
		repeat (2000) @(posedge mclk);
		err_count++;
		results();
	end
endmodule
bind acsf_top acsf_chk #(.NUM_CH(NUM_CH)) u_chk(.mclk, .reset, .avs_address, .avs_read,
	.avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .conv_done, .conv_start,
	.conv_sleep, .ch_enable);
